// ---- rtl/dma_list_ctrl_map.vh ----
// Register offsets, field positions and reset values of the DMA list control block
`ifndef DMA_LIST_CTRL_MAP_VH
`define DMA_LIST_CTRL_MAP_VH
`define OFS_TX_START 8'h08
`define OFS_RX_START 8'h0C
`define OFS_TX_LIST_BASE 8'h10
`define OFS_RX_LIST_BASE 8'h14
`define OFS_RX_CONTROL 8'h18
`define OFS_DMA_STATUS 8'h1C
`define OFS_HASH_LOW 8'h20
`define OFS_HASH_HIGH 8'h24
`define OFS_FILTER_DATA 8'h30
`define RESET_WORD 32'h00000000
`define RESET_RX_CONTROL 32'h00000000
`define RXC_ENABLE 0
`define RXC_HASH_ENABLE 1
`define RXC_RECEIVE_ALL 2
`define RXC_ALL_MULTICAST 5
`define PROC_STOPPED 2'h0
`define PROC_RUNNING 2'h1
`define PROC_SUSPENDED 2'h2
`define FIFO_DEPTH 16
`endif

// ---- rtl/sync_fifo.v ----
// Synchronous valid/ready FIFO built from flip-flops
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire arst_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doWrite;
  wire doRead;
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr];
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sync_fifo

// ---- rtl/mac_dma_list_control.v ----
// AHB-Lite register block: DMA start commands, list bases and multicast hash filter
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dma_list_ctrl_map.vh"
module mac_dma_list_control #(
  parameter FIFO_WIDTH = 8,
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire arst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output reg txPollReq,
  input wire txPollDone,
  input wire txDescAvailable,
  input wire txProcStop,
  output reg [1:0] txState,
  output reg rxPollReq,
  input wire rxPollDone,
  input wire rxDescAvailable,
  input wire rxProcStop,
  output reg [1:0] rxState,
  output reg [31:0] txListBase,
  output reg [31:0] rxListBase,
  input wire filtValid,
  output wire filtReady,
  input wire [5:0] filtCrcIndex,
  input wire filtMulticast,
  output wire rxEnable,
  output reg frameAccept,
  output reg frameAcceptValid,
  output wire [FIFO_WIDTH-1:0] dataOut,
  output wire dataOutValid,
  input wire dataOutReady
);
  reg wrPending;
  reg [7:0] wrAddr;
  reg [31:0] rxControl;
  reg [31:0] hashLow;
  reg [31:0] hashHigh;
  reg [FIFO_WIDTH-1:0] fifoInData;
  reg fifoInValid;
  wire fifoInReady;
  wire addrPhase;
  wire [7:0] rdAddr;
  reg [31:0] next_hrdata;
  reg hashHit;

  // Hash lookup: top index bit selects the word, the rest the bit
  function hash_lookup;
    input [5:0] idx;
    input [31:0] low;
    input [31:0] high;
    begin
      hash_lookup = idx[5] ? high[idx[4:0]] : low[idx[4:0]];
    end
  endfunction

  // Process state after a poll answer
  function [1:0] poll_result;
    input available;
    begin
      poll_result = available ? `PROC_RUNNING : `PROC_SUSPENDED;
    end
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];
  assign rdAddr = haddr[7:0];
  assign rxEnable = rxControl[`RXC_ENABLE];

  // Write data follows the address phase by one cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPending <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPending <= addrPhase && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txListBase <= `RESET_WORD;
      rxListBase <= `RESET_WORD;
      hashLow <= `RESET_WORD;
      hashHigh <= `RESET_WORD;
      rxControl <= `RESET_RX_CONTROL;
      txPollReq <= 1'b0;
      rxPollReq <= 1'b0;
    end else begin
      txPollReq <= 1'b0;
      rxPollReq <= 1'b0;
      if (wrPending) begin
        case (wrAddr)
          `OFS_TX_START: txPollReq <= 1'b1;
          `OFS_RX_START: rxPollReq <= 1'b1;
          `OFS_TX_LIST_BASE: txListBase <= hwdata;
          `OFS_RX_LIST_BASE: rxListBase <= hwdata;
          `OFS_RX_CONTROL: rxControl <= hwdata;
          `OFS_HASH_LOW: hashLow <= hwdata;
          `OFS_HASH_HIGH: hashHigh <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // Transmit process state
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txState <= `PROC_STOPPED;
    end else if (txProcStop) begin
      txState <= `PROC_STOPPED;
    end else if (txPollDone) begin
      txState <= poll_result(txDescAvailable);
    end
  end

  // Receive process state; suspended waits for the next start write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState <= `PROC_STOPPED;
    end else if (rxProcStop || !rxControl[`RXC_ENABLE]) begin
      rxState <= `PROC_STOPPED;
    end else if (rxPollDone) begin
      rxState <= poll_result(rxDescAvailable);
    end else if (rxState == `PROC_STOPPED) begin
      rxState <= `PROC_RUNNING;
    end
  end

  always @* begin
    case (rdAddr)
      `OFS_TX_START: next_hrdata = 32'h00000000;
      `OFS_RX_START: next_hrdata = 32'h00000000;
      `OFS_TX_LIST_BASE: next_hrdata = txListBase;
      `OFS_RX_LIST_BASE: next_hrdata = rxListBase;
      `OFS_RX_CONTROL: next_hrdata = rxControl;
      `OFS_DMA_STATUS: next_hrdata = {26'h0000000, fifoInReady, dataOutValid, rxState, txState};
      `OFS_HASH_LOW: next_hrdata = hashLow;
      `OFS_HASH_HIGH: next_hrdata = hashHigh;
      default: next_hrdata = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Filter decision
  always @* begin
    hashHit = rxControl[`RXC_HASH_ENABLE] && hash_lookup(filtCrcIndex, hashLow, hashHigh);
  end

  assign filtReady = fifoInReady;

  // Push in the cycle the frame is taken, so a full FIFO never loses an accepted frame
  always @* begin
    fifoInValid = filtValid && filtMulticast && (hashHit || rxControl[`RXC_RECEIVE_ALL] ||
      rxControl[`RXC_ALL_MULTICAST]);
    fifoInData = {{(FIFO_WIDTH-6){1'b0}}, filtCrcIndex};
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frameAccept <= 1'b0;
      frameAcceptValid <= 1'b0;
    end else begin
      frameAcceptValid <= filtValid && fifoInReady;
      if (filtValid && fifoInReady) begin
        frameAccept <= fifoInValid;
      end
    end
  end

  sync_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) acceptedFifo (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(dataOutValid),
    .outReady(dataOutReady),
    .outData(dataOut)
  );
endmodule // mac_dma_list_control

// ---- sim/mac_dma_list_control_checker.sv ----
// Port checks for the DMA list control block
`timescale 1ns/1ps
module mac_dma_list_control_checker (
  input wire clk,
  input wire arst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire txPollReq,
  input wire txPollDone,
  input wire txDescAvailable,
  input wire txProcStop,
  input wire [1:0] txState,
  input wire rxPollReq,
  input wire [31:0] txListBase,
  input wire filtValid,
  input wire filtReady,
  input wire filtMulticast,
  input wire frameAccept,
  input wire frameAcceptValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire ap = hsel && hready && htrans[1];
  sequence acc(a, w);
    ap && hwrite == w && haddr[7:0] == a;
  endsequence
  sequence done(av);
    txPollDone && txDescAvailable == av && !txProcStop;
  endsequence
  tx_poll_a: assert property (acc(8'h08, 1) |-> ##2 txPollReq)
    else $error("tx poll missing");
  tx_clear_a: assert property (txPollReq |=> !txPollReq)
    else $error("tx poll stuck");
  rx_poll_a: assert property (acc(8'h0C, 1) |-> ##2 rxPollReq)
    else $error("rx poll missing");
  tx_suspend_a: assert property (done(0) |=> txState == 2'h2)
    else $error("tx not suspended");
  tx_resume_a: assert property (done(1) |=> txState == 2'h1)
    else $error("tx not running");
  read_quiet_a: assert property (acc(8'h08, 0) |-> ##2 !txPollReq)
    else $error("read started poll");
  base_write_a: assert property (acc(8'h10, 1) ##1 1 |=> txListBase == $past(hwdata))
    else $error("tx base not written");
  filter_answer_a: assert property (filtValid && filtReady |=>
    frameAcceptValid && ($past(filtMulticast) || !frameAccept)) else $error("bad filter answer");
endmodule // mac_dma_list_control_checker

// ---- sim/dma_engine_model.sv ----
// Behavioural DMA engine answering descriptor polls
`timescale 1ns/1ps
module dma_engine_model #(
  parameter [3:0] LAT = 4'h1
) (
  input wire clk,
  input wire arst_n,
  input wire pollReq,
  input wire avail,
  output reg pollDone,
  output reg descAvailable
);
  reg [3:0] cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      pollDone <= 1'b0;
      descAvailable <= 1'b0;
    end else begin
      pollDone <= cnt == 4'h1;
      // Outside an answer the level is not held
      descAvailable <= (cnt == 4'h1) ? avail : ~descAvailable;
      if (pollReq) cnt <= LAT;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule // dma_engine_model

// ---- sim/tb.sv ----
// Self-checking bench for the DMA list control block
`timescale 1ns/1ps
module tb;
  reg clk = 0, arst_n = 0, hsel = 0, hwrite = 0, txProcStop = 0, rxProcStop = 0;
  reg txAvail = 0, rxAvail = 0, filtValid = 0, filtMulticast = 0, dataOutReady = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0;
  reg [2:0] hsize = 3'h2;
  reg [5:0] filtCrcIndex = 0;
  wire hreadyout, hresp, txPollReq, rxPollReq, txPollDone, rxPollDone;
  wire txDescAvailable, rxDescAvailable, rxEnable, frameAccept, frameAcceptValid;
  wire filtReady, dataOutValid;
  wire hready = hreadyout;
  wire [1:0] txState, rxState;
  wire [31:0] hrdata, txListBase, rxListBase;
  wire [7:0] dataOut;
  integer badCount = 0, testsRun = 0, i, n;
  mac_dma_list_control u_mac_dma_list_control (.*);
  dma_engine_model #(.LAT(4'h1)) u_tx_engine (.clk(clk), .arst_n(arst_n), .pollReq(txPollReq),
    .avail(txAvail), .pollDone(txPollDone), .descAvailable(txDescAvailable));
  dma_engine_model #(.LAT(4'h5)) u_rx_engine (.clk(clk), .arst_n(arst_n), .pollReq(rxPollReq),
    .avail(rxAvail), .pollDone(rxPollDone), .descAvailable(rxDescAvailable));
  initial forever #25 clk = ~clk;
  task chk(input [31:0] g, input [31:0] e);
    begin
      testsRun = testsRun + 1;
      if (g !== e) begin
        badCount = badCount + 1;
        $display("Error %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (!hready) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (!hready) @(posedge clk);
      rd = hrdata;
    end
  endtask
  task regScan;
    reg [7:0] a;
    reg [31:0] v;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        a = 56'h10142024400C08 >> (48 - 8 * i);
        v = 32'h3C00_0000 | (i << 8);
        ahb(1'b0, a, 32'h0);
        chk(rd, 32'h0);
        ahb(1'b1, a, v);
        ahb(1'b0, a, 32'h0);
        chk(rd, (i < 4) ? v : 32'h0);
      end
    end
  endtask
  task poll(input rx, input av, input [1:0] st);
    begin
      if (rx) rxAvail <= av;
      else txAvail <= av;
      ahb(1'b1, rx ? 8'h0C : 8'h08, 32'hFFFF_FFFF);
      n = 0;
      while (!(rx ? rxPollDone : txPollDone) && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      #1 chk(rx ? rxState : txState, st);
      @(posedge clk);
    end
  endtask
  task hashScan;
    reg [15:0] c;
    begin
      ahb(1'b1, 8'h20, 32'h8000_0001);
      ahb(1'b1, 8'h24, 32'h0000_0004);
      for (i = 0; i < 9; i = i + 1) begin
        c = 144'h0303_037F_038B_030A_0306_0300_0102_0507_2107 >> (128 - 16 * i);
        ahb(1'b1, 8'h18, {24'h0, c[15:8]});
        filtValid <= 1'b1;
        filtCrcIndex <= c[7:2];
        filtMulticast <= c[1];
        @(posedge clk);
        filtValid <= 1'b0;
        #1 chk({frameAcceptValid, frameAccept}, {1'b1, c[0]});
        @(posedge clk);
      end
    end
  endtask
  task fifoFill;
    begin
      dataOutReady <= 1'b0;
      filtValid <= 1'b1;
      repeat (40) @(posedge clk);
      filtValid <= 1'b0;
      #1 chk(filtReady, 1'b0);
      @(posedge clk);
      dataOutReady <= 1'b1;
      n = 0;
      repeat (40) begin
        @(posedge clk);
        if (dataOutValid) n = n + 1;
      end
      chk(n, 16);
    end
  endtask
  task stopTest;
    begin
      $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    hsel <= 1'b1;
    dataOutReady <= 1'b1;
    regScan;
    poll(1'b0, 1'b0, 2'h2);
    poll(1'b0, 1'b1, 2'h1);
    ahb(1'b1, 8'h18, 32'h1);
    poll(1'b1, 1'b0, 2'h2);
    repeat (8) @(posedge clk);
    #1 chk(rxState, 2'h2);
    @(posedge clk);
    poll(1'b1, 1'b1, 2'h1);
    hashScan;
    fifoFill;
    stopTest;
  end
  initial begin
    #1000000;
    badCount = badCount + 1;
    stopTest;
  end
endmodule // tb
bind mac_dma_list_control mac_dma_list_control_checker u_checker (.*);
